// ===== design/mad_top.sv
/*
  Memory attribute table, region selector, limit alias path and access check.
  Assumes register port and access requests come from logic on ref_clk.
*/
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - A limit alias access n reaches the region formed from selector bits [7:2] and n in the low two bits.
// - Both attribute registers exist once per Security state and each access uses its own state's copy.
// - The low attribute register holds slots 0 to 3, slot n at bits [8n+7:8n].
// - The high attribute register holds slots 4 to 7, slot n at bits [8(n-4)+7:8(n-4)].
// - An upper nibble of 0000 means device memory, with bits [3:2] giving the ordering class.
// - A nonzero upper nibble means normal memory, and 0100 there means outer non-cacheable.
// - Outer top bits give write-through or write-back, transient or not, and transient low bits are never 00.
// - The inner nibble uses the same scheme, 0100 is inner non-cacheable and 0000 is unpredictable.
// - In a cacheable nibble the low two bits request read and write allocation when set.
// - An access that breaks its matching region's permissions raises a memory-management fault.
// - A region's attribute index in limit bits [3:1] picks which of the eight slots applies.
module mad_top
  import mad_pkg::*;
#(
  parameter int NUM_REGIONS = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [mad_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mad_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mad_pkg::DATA_W-1:0] reg_rdata,
  // Security state of register accesses
  input wire logic cur_secure,
  // Access check request
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_priv,
  input wire logic acc_secure,
  output logic acc_ready,
  // Access check result
  output logic chk_done,
  output logic chk_hit,
  output logic chk_fault,
  output logic [7:0] chk_region,
  output mad_pkg::mad_attr_t chk_attr,
  output logic memory_management_fault
);
  import mad_pkg::*;

  localparam int RW = $clog2(NUM_REGIONS);
  localparam int AW = RW + 1;
  localparam logic [RW-1:0] LAST_IDX = RW'(NUM_REGIONS - 1);

  initial begin
    if (NUM_REGIONS < 4 || NUM_REGIONS > 256 || NUM_REGIONS != (1 << RW)) begin
      $error("NUM_REGIONS must be a power of two from 4 to 256");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DRAIN, ST_DONE} mad_state_t;

  function automatic logic [1:0] alias_num(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_ALIAS1: alias_num = 2'd1;
      OFF_ALIAS2: alias_num = 2'd2;
      OFF_ALIAS3: alias_num = 2'd3;
      default: alias_num = 2'd0;
    endcase
  endfunction

  function automatic logic [7:0] slot_of(input logic [31:0] lo, input logic [31:0] hi, input logic [2:0] idx);
    logic [31:0] w;
    w = idx[2] ? hi : lo;
    slot_of = w[idx[1:0] * SLOT_W +: SLOT_W];
  endfunction

  // Banked state, index 1 is secure; the fault status below is held once for both states
  logic [7:0] sel_r [2];
  logic [31:0] attr_lo_r [2];
  logic [31:0] attr_hi_r [2];
  logic fault_sticky_r;
  logic [7:0] fault_region_r;

  logic wr_sel, wr_base, wr_lim, wr_alias, wr_lo, wr_hi, wr_stat;
  logic [1:0] alias_n;
  logic [7:0] cur_sel;
  logic [7:0] tgt_region;
  logic tgt_ok;

  assign cur_sel = sel_r[cur_secure];
  assign alias_n = alias_num(reg_addr);
  assign wr_sel = reg_wr && reg_addr == OFF_SEL;
  assign wr_base = reg_wr && reg_addr == OFF_BASE;
  assign wr_lim = reg_wr && reg_addr == OFF_LIMIT;
  assign wr_alias = reg_wr && alias_n != 2'd0;
  assign wr_lo = reg_wr && reg_addr == OFF_ATTR_LO;
  assign wr_hi = reg_wr && reg_addr == OFF_ATTR_HI;
  assign wr_stat = reg_wr && reg_addr == OFF_STATUS;

  // Alias forms its target without touching the stored selector
  assign tgt_region = (alias_n != 2'd0) ? {cur_sel[7:2], alias_n} : cur_sel;
  // Unimplemented regions are ignored rather than aliased onto real ones
  assign tgt_ok = {1'b0, tgt_region} < 9'(NUM_REGIONS);

  mad_mem_if #(.AW(AW)) mi ();
  mad_attr_if ai ();

  mad_region_mem #(.DEPTH(2 * NUM_REGIONS), .AW(AW)) u_mem (
    .clk(ref_clk),
    .m(mi.mem)
  );

  mad_attr_dec u_dec (
    .a(ai.dec_side)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_r[0] <= SEL_RST;
      sel_r[1] <= SEL_RST;
    end else if (wr_sel) begin
      sel_r[cur_secure] <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      attr_lo_r[0] <= ATTR_RST;
      attr_lo_r[1] <= ATTR_RST;
      attr_hi_r[0] <= ATTR_RST;
      attr_hi_r[1] <= ATTR_RST;
    end else begin
      if (wr_lo) begin
        attr_lo_r[cur_secure] <= reg_wdata;
      end
      if (wr_hi) begin
        attr_hi_r[cur_secure] <= reg_wdata;
      end
    end
  end

  // Region words: bus writes use the write port, bus reads use port A
  always_comb begin
    mi.wr_en = (wr_base || wr_lim || wr_alias) && tgt_ok;
    mi.wr_lim = !wr_base;
    mi.wr_addr = {cur_secure, tgt_region[RW-1:0]};
    mi.wr_data = wr_base ? reg_wdata : (reg_wdata & LIMIT_WMASK);
    mi.ra_addr = {cur_secure, tgt_region[RW-1:0]};
    mi.ra_lim = reg_addr != OFF_BASE;
  end

  // Read path
  logic rd_mem_r;
  logic [31:0] rd_reg_r;
  logic rd_mem_hit;

  assign rd_mem_hit = (reg_addr == OFF_BASE || reg_addr == OFF_LIMIT || alias_num(reg_addr) != 2'd0) && tgt_ok;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_mem_r <= 1'b0;
      rd_reg_r <= '0;
    end else begin
      rd_mem_r <= reg_rd && rd_mem_hit;
      if (reg_rd) begin
        case (reg_addr)
          OFF_SEL: rd_reg_r <= {24'h000000, cur_sel};
          OFF_ATTR_LO: rd_reg_r <= attr_lo_r[cur_secure];
          OFF_ATTR_HI: rd_reg_r <= attr_hi_r[cur_secure];
          OFF_STATUS: rd_reg_r <= {16'h0000, fault_region_r, 7'h00, fault_sticky_r};
          default: rd_reg_r <= '0;
        endcase
      end else begin
        rd_reg_r <= '0;
      end
    end
  end

  assign reg_rdata = rd_mem_r ? mi.ra_data : rd_reg_r;

  // Access check: walk all regions, the highest-numbered match wins
  mad_state_t state_r;
  logic [RW-1:0] scan_r;
  logic [RW-1:0] eval_r;
  logic eval_v_r;
  logic [31:0] a_addr_r;
  logic a_wr_r, a_priv_r, a_sec_r;
  logic hit_r;
  logic [RW-1:0] hit_idx_r;
  logic [31:0] hit_base_r, hit_lim_r;

  assign acc_ready = state_r == ST_IDLE;
  assign mi.rb_addr = {a_sec_r, scan_r};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      scan_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          scan_r <= '0;
          if (acc_valid) begin
            state_r <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (scan_r == LAST_IDX) begin
            state_r <= ST_DRAIN;
          end else begin
            scan_r <= scan_r + 1'b1;
          end
        end
        ST_DRAIN: state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      a_addr_r <= '0;
      a_wr_r <= 1'b0;
      a_priv_r <= 1'b0;
      a_sec_r <= 1'b0;
    end else if (acc_valid && acc_ready) begin
      a_addr_r <= acc_addr;
      a_wr_r <= acc_write;
      a_priv_r <= acc_priv;
      a_sec_r <= acc_secure;
    end
  end

  logic [31:0] rb_base, rb_lim;
  logic rb_match;

  assign rb_base = mi.rb_data[63:32];
  assign rb_lim = mi.rb_data[31:0];
  assign rb_match = rb_lim[LIM_EN] && a_addr_r[31:ADDR_LSB] >= rb_base[31:ADDR_LSB]
    && a_addr_r[31:ADDR_LSB] <= rb_lim[31:ADDR_LSB];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      eval_v_r <= 1'b0;
      eval_r <= '0;
      hit_r <= 1'b0;
      hit_idx_r <= '0;
      hit_base_r <= '0;
      hit_lim_r <= '0;
    end else begin
      eval_v_r <= state_r == ST_SCAN;
      eval_r <= scan_r;
      if (acc_valid && acc_ready) begin
        hit_r <= 1'b0;
      end else if (eval_v_r && rb_match) begin
        hit_r <= 1'b1;
        hit_idx_r <= eval_r;
        hit_base_r <= rb_base;
        hit_lim_r <= rb_lim;
      end
    end
  end

  logic viol;
  logic [2:0] hit_slot;

  // Write to read-only, or unprivileged to privileged-only
  assign viol = (a_wr_r && hit_base_r[AP_RO]) || (!a_priv_r && !hit_base_r[AP_ANY]);
  assign hit_slot = hit_lim_r[LIM_IDX_LSB +: 3];
  assign ai.attr_byte = slot_of(attr_lo_r[a_sec_r], attr_hi_r[a_sec_r], hit_slot);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chk_done <= 1'b0;
      chk_hit <= 1'b0;
      chk_fault <= 1'b0;
      chk_region <= '0;
      chk_attr <= '0;
      memory_management_fault <= 1'b0;
    end else begin
      chk_done <= state_r == ST_DONE;
      memory_management_fault <= state_r == ST_DONE && hit_r && viol;
      if (state_r == ST_DONE) begin
        chk_hit <= hit_r;
        chk_fault <= hit_r && viol;
        chk_region <= 8'(hit_idx_r);
        chk_attr <= ai.dec;
      end
    end
  end

  // Fault status: hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fault_sticky_r <= 1'b0;
      fault_region_r <= '0;
    end else begin
      if (state_r == ST_DONE && hit_r && viol) begin
        fault_sticky_r <= 1'b1;
        fault_region_r <= 8'(hit_idx_r);
      end else if (wr_stat && reg_wdata[STAT_FAULT]) begin
        fault_sticky_r <= 1'b0;
      end
    end
  end

  // Checks
  chk_alias_keeps_sel: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_alias |=> sel_r[$past(cur_secure)] == $past(cur_sel))
    else $error("alias access changed the region selector");

  chk_alias_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_alias && mi.wr_en |-> mi.wr_addr[1:0] == alias_n && tgt_region[7:2] == cur_sel[7:2])
    else $error("alias access reached the wrong region");

  chk_bank_isolated: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_lo || wr_hi) |=> attr_lo_r[!$past(cur_secure)] == $past(attr_lo_r[!cur_secure])
      && attr_hi_r[!$past(cur_secure)] == $past(attr_hi_r[!cur_secure]))
    else $error("attribute write leaked into the other Security state");

  chk_slot_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !hit_slot[2] |-> ai.attr_byte == attr_lo_r[a_sec_r][8 * hit_slot[1:0] +: 8])
    else $error("low slot selection wrong");

  chk_slot_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hit_slot[2] |-> ai.attr_byte == attr_hi_r[a_sec_r][8 * hit_slot[1:0] +: 8])
    else $error("high slot selection wrong");

  chk_device_class: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ai.attr_byte[7:4] == NIB_DEVICE |-> ai.dec.is_device && ai.dec.dev_class == ai.attr_byte[3:2])
    else $error("device class decode wrong");

  chk_outer_nc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ai.attr_byte[7:4] == NIB_NC |-> !ai.dec.is_device && ai.dec.outer.kind == CK_NC)
    else $error("outer non-cacheable decode wrong");

  chk_outer_policy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ai.attr_byte[7:4] != NIB_NC && ai.attr_byte[7:4] != NIB_DEVICE
      |-> ai.dec.outer.kind == (ai.attr_byte[6] ? CK_WB : CK_WT)
        && ai.dec.outer.transient == !ai.attr_byte[7]
        && ai.dec.outer.bad == (!ai.attr_byte[7] && ai.attr_byte[5:4] == NO_ALLOC))
    else $error("outer policy decode wrong");

  chk_inner_policy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ai.attr_byte[3:0] == NIB_DEVICE |-> ai.dec.inner.bad && ai.dec.inner.kind == CK_UNP)
    else $error("inner zero not flagged");

  chk_alloc_hints: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ai.dec.inner.kind inside {CK_WT, CK_WB} |-> {ai.dec.inner.ra, ai.dec.inner.wa} == ai.attr_byte[1:0])
    else $error("allocation hints wrong");

  chk_fault_timing: assert property (@(posedge ref_clk) disable iff (sys_rst)
    acc_valid && acc_ready |-> ##(NUM_REGIONS + 3) chk_done && (chk_fault == memory_management_fault))
    else $error("check result late or fault pulse mismatched");

  chk_fault_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
    memory_management_fault |-> chk_hit && $past(viol))
    else $error("fault without a violating matched region");

  cov_alias_write: cover property (@(posedge ref_clk) disable iff (sys_rst) wr_alias && mi.wr_en);
  cov_device_hit: cover property (@(posedge ref_clk) disable iff (sys_rst) chk_done && chk_attr.is_device);
  cov_fault: cover property (@(posedge ref_clk) disable iff (sys_rst) memory_management_fault);
  cov_secure_attr: cover property (@(posedge ref_clk) disable iff (sys_rst) wr_lo && cur_secure);
endmodule

// ===== design/mad_pkg.sv
/*
  Shared constants and types for the memory attribute decode block.
  Assumes a 32-bit register port with byte addresses.
*/
package mad_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SLOT_W = 8;
  localparam int SLOTS_PER_REG = 4;
  localparam logic [ADDR_W-1:0] OFF_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ALIAS1 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ALIAS2 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ALIAS3 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ATTR_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_ATTR_HI = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
  localparam logic [DATA_W-1:0] SEL_MASK = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] LIMIT_WMASK = 32'hFFFF_FFEF;
  localparam logic [DATA_W-1:0] ATTR_RST = 32'h0000_0000;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [4:0] ADDR_LOW_ZERO = 5'h00;
  localparam logic [4:0] ADDR_LOW_ONES = 5'h1F;
  localparam int LIM_EN = 0;
  localparam int LIM_IDX_LSB = 1;
  localparam int ADDR_LSB = 5;
  localparam int AP_ANY = 1;
  localparam int AP_RO = 2;
  localparam int STAT_FAULT = 0;
  localparam int STAT_REG_LSB = 8;
  localparam logic [3:0] NIB_DEVICE = 4'h0;
  localparam logic [3:0] NIB_NC = 4'h4;
  localparam logic [1:0] NO_ALLOC = 2'b00;

  typedef enum logic [1:0] {CK_NC, CK_WT, CK_WB, CK_UNP} mad_cache_t;

  typedef struct packed {
    mad_cache_t kind;
    logic transient;
    logic ra;
    logic wa;
    logic bad;
  } mad_nib_t;

  typedef struct packed {
    logic is_device;
    logic [1:0] dev_class;
    mad_nib_t outer;
    mad_nib_t inner;
  } mad_attr_t;

  // Same scheme serves outer and inner halves
  function automatic mad_nib_t mad_decode_nib(input logic [3:0] n);
    mad_nib_t d;
    d.ra = n[1];
    d.wa = n[0];
    d.transient = ~n[3];
    d.bad = 1'b0;
    if (n == NIB_NC) begin
      d.kind = CK_NC;
      d.ra = 1'b0;
      d.wa = 1'b0;
      d.transient = 1'b0;
    end else if (n == NIB_DEVICE) begin
      d.kind = CK_UNP;
      d.bad = 1'b1;
    end else begin
      d.kind = n[2] ? CK_WB : CK_WT;
      d.bad = ~n[3] & (n[1:0] == NO_ALLOC);
    end
    return d;
  endfunction
endpackage

// ===== design/mad_if.sv
/*
  Carriers between the top block and its memory and decoder.
  Assumes one clock shared by all parties.
*/
`timescale 1ns/1ps
interface mad_mem_if #(parameter int AW = 4);
  logic wr_en;
  logic wr_lim;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [AW-1:0] ra_addr;
  logic ra_lim;
  logic [31:0] ra_data;
  logic [AW-1:0] rb_addr;
  logic [63:0] rb_data;
  modport user (output wr_en, wr_lim, wr_addr, wr_data, ra_addr, ra_lim, rb_addr, input ra_data, rb_data);
  modport mem (input wr_en, wr_lim, wr_addr, wr_data, ra_addr, ra_lim, rb_addr, output ra_data, rb_data);
endinterface

interface mad_attr_if;
  import mad_pkg::*;
  logic [7:0] attr_byte;
  mad_attr_t dec;
  modport user (output attr_byte, input dec);
  modport dec_side (input attr_byte, output dec);
endinterface

// ===== design/mad_region_mem.sv
/*
  Banked region word store: base and limit per region and Security state.
  Assumes write and reads on the same clock; read data registered.
*/
`timescale 1ns/1ps
module mad_region_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk,
  // Access
  mad_mem_if.mem m
);
  logic [31:0] base_q [DEPTH];
  logic [31:0] lim_q [DEPTH];
  logic [31:0] ra_r;
  logic [63:0] rb_r;

  initial begin
    if (DEPTH != (1 << AW)) $error("DEPTH must be 2**AW");
  end

  always_ff @(posedge clk) begin
    if (m.wr_en) begin
      if (m.wr_lim) begin
        lim_q[m.wr_addr] <= m.wr_data;
      end else begin
        base_q[m.wr_addr] <= m.wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    ra_r <= m.ra_lim ? lim_q[m.ra_addr] : base_q[m.ra_addr];
    rb_r <= {base_q[m.rb_addr], lim_q[m.rb_addr]};
  end

  assign m.ra_data = ra_r;
  assign m.rb_data = rb_r;
endmodule

// ===== design/mad_attr_dec.sv
/*
  Combinational decode of one attribute byte.
  Assumes the caller registers what it needs.
*/
`timescale 1ns/1ps
module mad_attr_dec (
  // Byte in, decode out
  mad_attr_if.dec_side a
);
  import mad_pkg::*;

  always_comb begin
    a.dec.is_device = (a.attr_byte[7:4] == NIB_DEVICE);
    a.dec.dev_class = a.attr_byte[3:2];
    a.dec.outer = mad_decode_nib(a.attr_byte[7:4]);
    a.dec.inner = mad_decode_nib(a.attr_byte[3:0]);
  end
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench for mad_top: register map, banking, alias path, attribute decode, access faults.
  Assumes mad_pkg and the design files are compiled first; secure bank is used for access checks.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
  import mad_pkg::*;
  localparam int NR = 8;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic cur_secure = 1'b1;
  logic acc_valid = 1'b0;
  logic [31:0] acc_addr = '0;
  logic acc_write = 1'b0;
  logic acc_priv = 1'b0;
  logic acc_secure = 1'b1;
  logic acc_ready;
  logic chk_done;
  logic chk_hit;
  logic chk_fault;
  logic [7:0] chk_region;
  mad_attr_t chk_attr;
  logic memory_management_fault;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] d;

  mad_top #(.NUM_REGIONS(NR)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cur_secure(cur_secure),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_priv(acc_priv),
    .acc_secure(acc_secure), .acc_ready(acc_ready), .chk_done(chk_done), .chk_hit(chk_hit),
    .chk_fault(chk_fault), .chk_region(chk_region), .chk_attr(chk_attr),
    .memory_management_fault(memory_management_fault));

  always #10 ref_clk = ~ref_clk;

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v, input logic s);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    cur_secure <= s;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic s, output logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    cur_secure <= s;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge ref_clk);
    #1;
    `CHK(reg_rdata, 32'h0000_0000)
  endtask

  task automatic acc(input logic [31:0] a, input logic w, input logic p, input logic eh, input logic ef,
                     input logic [7:0] er);
    int n;
    @(posedge ref_clk);
    acc_addr <= a;
    acc_write <= w;
    acc_priv <= p;
    acc_valid <= 1'b1;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    #1;
    `CHK(acc_ready, 1'b0)
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (chk_done !== 1'b1 && n < 40);
    // Done shows ten edges after the taking edge for eight regions
    `CHK(n, NR + 2)
    `CHK(chk_hit, eh)
    `CHK(chk_fault, ef)
    `CHK(memory_management_fault, ef)
    if (eh) `CHK(chk_region, er)
    // Done and fault pulse last one cycle, result holds
    @(posedge ref_clk);
    #1;
    `CHK({chk_done, memory_management_fault, acc_ready, chk_fault}, {3'b001, ef})
  endtask

  function automatic mad_nib_t exp_nib(input logic [3:0] n);
    mad_nib_t e;
    e.ra = n[1];
    e.wa = n[0];
    e.transient = ~n[3];
    e.bad = ~n[3] & (n[1:0] == 2'b00);
    e.kind = n[2] ? CK_WB : CK_WT;
    if (n == 4'h4) begin
      e = '{kind: CK_NC, transient: 1'b0, ra: 1'b0, wa: 1'b0, bad: 1'b0};
    end else if (n == 4'h0) begin
      e.kind = CK_UNP;
      e.bad = 1'b1;
    end
    return e;
  endfunction

  task automatic t_reset_bank();
    for (int s = 0; s < 2; s++) begin
      rd(OFF_ATTR_LO, s[0], d);
      `CHK(d, 32'h0000_0000)
      rd(OFF_ATTR_HI, s[0], d);
      `CHK(d, 32'h0000_0000)
    end
    wr(OFF_ATTR_LO, 32'h1122_3344, 1'b1);
    wr(OFF_ATTR_LO, 32'hA5A5_5A5A, 1'b0);
    wr(OFF_ATTR_HI, 32'hDEAD_BEEF, 1'b1);
    wr(OFF_ATTR_HI, 32'h0F0F_F0F0, 1'b0);
    rd(OFF_ATTR_LO, 1'b1, d);
    `CHK(d, 32'h1122_3344)
    rd(OFF_ATTR_LO, 1'b0, d);
    `CHK(d, 32'hA5A5_5A5A)
    rd(OFF_ATTR_HI, 1'b1, d);
    `CHK(d, 32'hDEAD_BEEF)
    rd(OFF_ATTR_HI, 1'b0, d);
    `CHK(d, 32'h0F0F_F0F0)
    wr(8'h24, 32'hFFFF_FFFF, 1'b1);
    rd(8'h24, 1'b1, d);
    `CHK(d, 32'h0000_0000)
  endtask

  // Region store is not reset, so every secure-bank region is cleared first
  task automatic t_init();
    for (int r = 0; r < NR; r++) begin
      wr(OFF_SEL, 32'(r), 1'b1);
      wr(OFF_BASE, 32'h0000_0000, 1'b1);
      wr(OFF_LIMIT, 32'h0000_0000, 1'b1);
    end
    wr(OFF_SEL, 32'h0000_0000, 1'b1);
    wr(OFF_BASE, 32'h0000_0002, 1'b1);
  endtask

  task automatic t_decode();
    logic [7:0] t[8] = '{8'h44, 8'h12, 8'h73, 8'hAA, 8'hFF, 8'hB5, 8'h84, 8'h3C};
    logic [7:0] dv[4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    wr(OFF_ATTR_LO, {t[3], t[2], t[1], t[0]}, 1'b1);
    wr(OFF_ATTR_HI, {t[7], t[6], t[5], t[4]}, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_LIMIT, {27'h80, 1'b0, i[2:0], 1'b1}, 1'b1);
      acc(32'h0000_0100, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
      `CHK(chk_attr.is_device, 1'b0)
      `CHK(chk_attr.outer, exp_nib(t[i][7:4]))
      `CHK(chk_attr.inner, exp_nib(t[i][3:0]))
    end
    wr(OFF_ATTR_LO, {dv[3], dv[2], dv[1], dv[0]}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_LIMIT, {27'h80, 1'b0, i[2:0], 1'b1}, 1'b1);
      acc(32'h0000_0100, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
      `CHK(chk_attr.is_device, 1'b1)
      `CHK(chk_attr.dev_class, i[1:0])
    end
  endtask

  task automatic t_fault();
    wr(OFF_BASE, 32'h0000_0004, 1'b1);
    acc(32'h0000_0100, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    rd(OFF_STATUS, 1'b1, d);
    `CHK({d[15:8], d[0]}, 9'h001)
    wr(OFF_STATUS, 32'h0000_0001, 1'b1);
    rd(OFF_STATUS, 1'b1, d);
    `CHK(d[0], 1'b0)
    acc(32'h0000_0100, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    acc(32'h8000_0000, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_alias();
    wr(OFF_SEL, 32'h0000_0005, 1'b1);
    wr(OFF_ALIAS2, 32'h0000_2013, 1'b1);
    rd(OFF_SEL, 1'b1, d);
    `CHK(d, 32'h0000_0005)
    rd(OFF_ALIAS2, 1'b1, d);
    `CHK(d, 32'h0000_2003)
    wr(OFF_SEL, 32'h0000_0006, 1'b1);
    rd(OFF_LIMIT, 1'b1, d);
    `CHK(d, 32'h0000_2003)
    rd(OFF_ALIAS3, 1'b1, d);
    `CHK(d, 32'h0000_0000)
    acc(32'h0000_0100, 1'b0, 1'b1, 1'b1, 1'b0, 8'h06);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_bank();
    t_init();
    t_decode();
    t_fault();
    t_alias();
    print_verdict();
  end

  // Tests take about 380 cycles; allow over twenty-five times that
  initial begin
    #200000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
